/* File: cpu_clock_source_select.v */
`timescale 1ns/1ps
`default_nettype none
`include "cpu_clock_source_select_defines.vh"
module cpu_clock_source_select (
	input wire i_clk,
	input wire i_nrst,
	input wire [15:0] i_addr,
	input wire [7:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	input wire i_x1_clk_tick,
	input wire i_int_osc_tick,
	input wire i_sub_clk_tick,
	input wire i_int_osc_sw_stoppable,
	output reg [7:0] o_rdata,
	output reg o_cpu_clk_en,
	output reg o_instr_done,
	output reg o_periph_clk_en,
	output reg o_periph_on_internal,
	output reg o_x1_osc_stop,
	output reg o_internal_osc_stop,
	output reg o_sub_feedback_resistor_off
);
	localparam ST_IDLE = 2'h0;
	localparam ST_SETTLE = 2'h1;
	// pin order: mask option, subsystem, internal, X1
	wire [3:0] pin_raw;
	wire [3:0] pin_s;
	wire [2:0] pin_rise;
	reg [2:0] prev_pin_q;
	reg internal_osc_stop_q;
	reg cpu_source_select_bit_q;
	reg cpu_on_x1_status_q;
	reg x1_osc_stop_q;
	reg x1_stop_by_processor_reg_q;
	reg sub_feedback_resistor_off_q;
	reg subsystem_clock_select_q;
	reg cpu_on_subsystem_status_q;
	reg [2:0] div_sel_q;
	reg [1:0] state_q;
	reg [3:0] settle_q;
	reg [15:0] div_cnt_q;
	reg [15:0] div_cnt_d;
	reg instr_phase_q;
	reg [2:0] eff_div;
	reg [15:0] div_mask;
	reg x1_stop_d;
	reg [7:0] rdata_d;
	assign pin_raw = {i_int_osc_sw_stoppable, i_sub_clk_tick, i_int_osc_tick, i_x1_clk_tick};
	wire stoppable_s = pin_s[3];
	wire x1_rise = pin_rise[0];
	wire int_rise = pin_rise[1];
	wire sub_rise = pin_rise[2];
	wire wr_int_mode = i_wr & (i_addr == `ADDR_INTERNAL_OSC_MODE);
	wire wr_main_sel = i_wr & (i_addr == `ADDR_MAIN_CLOCK_SELECT);
	wire wr_main_osc = i_wr & (i_addr == `ADDR_MAIN_OSC_CONTROL);
	wire wr_proc_ctrl = i_wr & (i_addr == `ADDR_PROCESSOR_CLOCK_CONTROL);
	// settled source: internal when neither X1 nor subsystem status is set
	wire on_internal = ~cpu_on_x1_status_q & ~cpu_on_subsystem_status_q;
	wire main_rise = cpu_on_x1_status_q ? x1_rise : int_rise;
	wire src_rise = cpu_on_subsystem_status_q ? sub_rise : main_rise;
	// a request differs from the settled status
	wire switch_req = (cpu_source_select_bit_q != cpu_on_x1_status_q) ||
		(subsystem_clock_select_q != cpu_on_subsystem_status_q);
	wire settle_done = (settle_q == 4'h0);
	wire div_wrap = (div_cnt_q >= div_mask);
	// two-flop synchronisers, one per pin
	// clock levels are slow, so a level sample loses no edge
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : g_sync
			reg [1:0] sync_q;
			always @(posedge i_clk or negedge i_nrst)
			begin
				if (!i_nrst)
					sync_q <= 2'h0;
				else
					sync_q <= {sync_q[0], pin_raw[g]};
			end
			assign pin_s[g] = sync_q[1];
		end
	endgenerate
	// rising edges of the three clock levels
	// low after reset, matching the idle pin level
	always @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			prev_pin_q <= 3'h0;
		else
			prev_pin_q <= pin_s[2:0];
	end
	assign pin_rise = pin_s[2:0] & ~prev_pin_q;
	// divider ratio after clamping
	always @*
	begin
		eff_div = div_sel_q;
		if (eff_div > `DIV_MAX)
			eff_div = `DIV_MAX;
		if (on_internal && eff_div > `DIV_INTERNAL_MAX)
			eff_div = `DIV_INTERNAL_MAX;
		if (cpu_on_subsystem_status_q)
			eff_div = 3'h1;
		div_mask = (16'h0001 << eff_div) - 16'h0001;
	end
	// divider count, advanced on each source edge
	always @*
	begin
		div_cnt_d = div_cnt_q;
		if (src_rise)
			div_cnt_d = div_wrap ? 16'h0000 : div_cnt_q + 16'h0001;
	end
	// X1 stop source depends on the settled cpu clock
	always @*
	begin
		if (on_internal)
			x1_stop_d = x1_osc_stop_q;
		else if (cpu_on_subsystem_status_q)
			x1_stop_d = x1_stop_by_processor_reg_q;
		else
			x1_stop_d = 1'b0;
	end
	// read mux, zero outside a read
	always @*
	begin
		rdata_d = 8'h00;
		if (i_rd)
		begin
			case (i_addr)
				`ADDR_INTERNAL_OSC_MODE:
					rdata_d = {7'h00, internal_osc_stop_q};
				`ADDR_MAIN_CLOCK_SELECT:
					rdata_d = {6'h00, cpu_on_x1_status_q, cpu_source_select_bit_q};
				`ADDR_MAIN_OSC_CONTROL:
					rdata_d = {x1_osc_stop_q, 7'h00};
				`ADDR_PROCESSOR_CLOCK_CONTROL:
					rdata_d = {x1_stop_by_processor_reg_q, sub_feedback_resistor_off_q,
						cpu_on_subsystem_status_q, subsystem_clock_select_q,
						1'b0, div_sel_q};
				default:
					rdata_d = 8'h00;
			endcase
		end
	end
	// internal osc mode: stop bit honoured only off the internal clock
	// forced clear keeps a stale stop from killing the running cpu clock
	always @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			internal_osc_stop_q <= 1'b0;
		else if (wr_int_mode && stoppable_s && !on_internal)
			internal_osc_stop_q <= i_wdata[`BIT_INTERNAL_OSC_STOP];
		else if (on_internal)
			internal_osc_stop_q <= 1'b0;
	end
	// main clock select; the status bit is never written
	always @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			cpu_source_select_bit_q <= 1'b0;
		else if (wr_main_sel)
			cpu_source_select_bit_q <= i_wdata[`BIT_CPU_SOURCE_SELECT];
	end
	// main osc control: X1 stop bit
	always @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			x1_osc_stop_q <= 1'b0;
		else if (wr_main_osc)
			x1_osc_stop_q <= i_wdata[`BIT_X1_OSC_STOP];
	end
	// processor clock control: X1 stop, feedback resistor, subsystem select, divider
	always @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			x1_stop_by_processor_reg_q <= 1'b0;
			sub_feedback_resistor_off_q <= 1'b0;
			subsystem_clock_select_q <= 1'b0;
			div_sel_q <= 3'h0;
		end
		else if (wr_proc_ctrl)
		begin
			x1_stop_by_processor_reg_q <= i_wdata[`BIT_X1_STOP_BY_PROC];
			sub_feedback_resistor_off_q <= i_wdata[`BIT_SUB_FB_OFF];
			subsystem_clock_select_q <= i_wdata[`BIT_SUBSYSTEM_SELECT];
			div_sel_q <= i_wdata[`DIV_HI:`DIV_LO];
		end
	end
	// source switch: gate cpu clock, settle, then update status
	// status moves only after settle, so the mux never sees a runt pulse
	always @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			state_q <= ST_IDLE;
			settle_q <= 4'h0;
			cpu_on_x1_status_q <= 1'b0;
			cpu_on_subsystem_status_q <= 1'b0;
		end
		else
		begin
			case (state_q)
				ST_IDLE:
				begin
					if (switch_req)
					begin
						state_q <= ST_SETTLE;
						settle_q <= `SWITCH_SETTLE_CYCLES;
					end
				end
				ST_SETTLE:
				begin
					if (settle_done)
					begin
						cpu_on_x1_status_q <= cpu_source_select_bit_q;
						cpu_on_subsystem_status_q <= subsystem_clock_select_q;
						state_q <= ST_IDLE;
					end
					else
						settle_q <= settle_q - 4'h1;
				end
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end
	// divider and cpu clock enable, silent while switching
	always @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			div_cnt_q <= 16'h0000;
			o_cpu_clk_en <= 1'b0;
		end
		else
		begin
			div_cnt_q <= div_cnt_d;
			o_cpu_clk_en <= (state_q == ST_IDLE) && src_rise && div_wrap;
		end
	end
	// instruction end on every second cpu clock
	always @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			instr_phase_q <= 1'b0;
			o_instr_done <= 1'b0;
		end
		else
		begin
			if (o_cpu_clk_en)
				instr_phase_q <= ~instr_phase_q;
			o_instr_done <= o_cpu_clk_en & instr_phase_q;
		end
	end
	// peripheral clock follows the main system clock
	always @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			o_periph_clk_en <= 1'b0;
		else
			o_periph_clk_en <= main_rise;
	end
	// peripherals flagged as running from the internal oscillator
	always @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			o_periph_on_internal <= 1'b1;
		else
			o_periph_on_internal <= ~cpu_on_x1_status_q;
	end
	// X1 oscillator stop
	always @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			o_x1_osc_stop <= 1'b0;
		else
			o_x1_osc_stop <= x1_stop_d;
	end
	// internal oscillator stop and feedback resistor
	always @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_internal_osc_stop <= 1'b0;
			o_sub_feedback_resistor_off <= 1'b0;
		end
		else
		begin
			o_internal_osc_stop <= internal_osc_stop_q;
			o_sub_feedback_resistor_off <= sub_feedback_resistor_off_q;
		end
	end
	// read data, one cycle after the read strobe
	always @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			o_rdata <= 8'h00;
		else
			o_rdata <= rdata_d;
	end
endmodule // cpu_clock_source_select
`default_nettype wire

/* File: cpu_clock_source_select_defines.vh */
// Function
// - on internal clock, X1 stops only via main osc stop bit 7
// - fastest instruction takes two cpu clock periods
// - main system clock is X1 or internal clock per select bit
// - internal osc stop acts only if mask allows and X1/subsystem drives cpu
// - internal osc mode register takes bit and byte writes
// - internal osc mode bit 0: 0 runs, 1 stops oscillator
// - main clock bit 1 read-only: 0 internal, 1 X1 drives cpu
// - main clock bit 0 selects cpu source: 0 internal, 1 X1
// - main clock register takes bit and byte writes; status ignores writes
// - with internal clock selected, peripherals run from internal oscillator output
// - divider gives main clock /1..16 or subsystem/2; internal allows only /1, /2
`ifndef CPU_CLOCK_SOURCE_SELECT_DEFINES_VH
`define CPU_CLOCK_SOURCE_SELECT_DEFINES_VH
`define ADDR_INTERNAL_OSC_MODE 16'hFFA0
`define ADDR_MAIN_CLOCK_SELECT 16'hFFA1
`define ADDR_MAIN_OSC_CONTROL 16'hFFA2
`define ADDR_PROCESSOR_CLOCK_CONTROL 16'hFFFB
`define RST_INTERNAL_OSC_MODE 8'h00
`define RST_MAIN_CLOCK_SELECT 8'h00
`define RST_MAIN_OSC_CONTROL 8'h00
`define RST_PROCESSOR_CLOCK_CONTROL 8'h00
`define BIT_INTERNAL_OSC_STOP 0
`define BIT_CPU_SOURCE_SELECT 0
`define BIT_CPU_ON_X1_STATUS 1
`define BIT_X1_OSC_STOP 7
`define BIT_X1_STOP_BY_PROC 7
`define BIT_SUB_FB_OFF 6
`define BIT_CPU_ON_SUB_STATUS 5
`define BIT_SUBSYSTEM_SELECT 4
`define BIT_PROC_RESERVED 3
`define DIV_HI 2
`define DIV_LO 0
`define DIV_MAX 3'h4
`define DIV_INTERNAL_MAX 3'h1
`define SWITCH_SETTLE_CYCLES 4'h3
`define INSTR_MIN_CPU_CYCLES 2
`endif

/* File: cpu_clock_source_select_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module cpu_clock_source_select_sva (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic [15:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic o_cpu_clk_en,
	input wire logic o_instr_done,
	input wire logic o_periph_clk_en,
	input wire logic o_periph_on_internal,
	input wire logic o_x1_osc_stop,
	input wire logic o_internal_osc_stop
);
// cpu clock pulses since last instruction end
logic [1:0] en_cnt_q;
always_ff @(posedge i_clk or negedge i_nrst)
	if (!i_nrst)
		en_cnt_q <= 2'h0;
	else if (o_instr_done)
		en_cnt_q <= 2'h0;
	else if (o_cpu_clk_en && en_cnt_q != 2'h3)
		en_cnt_q <= en_cnt_q + 2'h1;
default clocking @(posedge i_clk); endclocking
default disable iff (!i_nrst);
AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
	else $error("read data outside read cycle");
AST_OSC_MODE_RD: assert property ($past(i_rd) && $past(i_addr) == 16'hFFA0 |->
	o_rdata[7:1] == 7'h00) else $error("osc mode spare bits set");
AST_MAIN_SEL_RD: assert property ($past(i_rd) && $past(i_addr) == 16'hFFA1 |->
	o_rdata[7:2] == 6'h00) else $error("main select spare bits set");
AST_INT_STOP: assert property ($rose(o_internal_osc_stop) |-> !o_periph_on_internal)
	else $error("internal stop while on internal clock");
AST_X1_STOP: assert property ($rose(o_x1_osc_stop) |-> $past(i_wr) || $past(i_wr, 2))
	else $error("x1 stop without write");
AST_PCLK: assert property (o_periph_clk_en |=> !o_periph_clk_en)
	else $error("peripheral enable too long");
AST_CPUCLK: assert property (o_cpu_clk_en |=> !o_cpu_clk_en)
	else $error("cpu enable too long");
AST_INSTR: assert property (o_instr_done |-> en_cnt_q == 2'h2)
	else $error("instruction shorter than two clocks");
AST_SETTLE: assert property (i_wr && i_addr == 16'hFFA1 && i_wdata[0] && o_periph_on_internal
	|=> o_periph_on_internal[*3]) else $error("status changed before settle");
endmodule // cpu_clock_source_select_sva
bind cpu_clock_source_select cpu_clock_source_select_sva i_cpu_clock_source_select_sva (.*);
`default_nettype wire

/* File: cpu_clock_source_select_test.sv */
`timescale 1ns/1ps
`default_nettype none
module cpu_clock_source_select_test;
logic i_clk, i_nrst, i_wr, i_rd, i_int_osc_sw_stoppable;
logic i_x1_clk_tick, i_int_osc_tick, i_sub_clk_tick;
logic [15:0] i_addr;
logic [7:0] i_wdata, o_rdata;
logic o_cpu_clk_en, o_instr_done, o_periph_clk_en, o_periph_on_internal;
logic o_x1_osc_stop, o_internal_osc_stop, o_sub_feedback_resistor_off;
logic [6:0] tc;
int err_count;
int num_checks;
cpu_clock_source_select i_cpu_clock_source_select (.*);
initial
begin
	i_clk = 1'b0;
	forever #5 i_clk = ~i_clk;
end
// slow source clocks
always @(posedge i_clk)
	tc <= tc + 7'h01;
always @(posedge i_clk)
	{i_sub_clk_tick, i_int_osc_tick, i_x1_clk_tick} <= {tc[6], tc[4], tc[3]};
task automatic chk(input logic [7:0] got, input logic [7:0] exp);
	num_checks++;
	if (got !== exp)
	begin
		err_count++;
		$display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
	end
endtask
task automatic wr(input logic [15:0] a, input logic [7:0] d);
	@(posedge i_clk);
	i_wr <= 1'b1;
	i_addr <= a;
	i_wdata <= d;
	@(posedge i_clk);
	i_wr <= 1'b0;
	@(posedge i_clk) #1;
endtask
task automatic rd(input logic [15:0] a, input logic [7:0] exp);
	@(posedge i_clk);
	i_rd <= 1'b1;
	i_addr <= a;
	@(posedge i_clk);
	i_rd <= 1'b0;
	#1 chk(o_rdata, exp);
endtask
task automatic settle(input logic v);
	for (int k = 0; k < 60 && o_periph_on_internal !== v; k++)
		@(posedge i_clk) #1;
	chk({7'h00, o_periph_on_internal}, {7'h00, v});
endtask
function automatic logic pick(input logic [1:0] s);
	if (s == 2'h0)
		return o_cpu_clk_en;
	else if (s == 2'h1)
		return o_periph_clk_en;
	else
		return o_instr_done;
endfunction
// cycles between two pulses of the picked output
task automatic gap(input logic [1:0] sel, input logic [7:0] exp);
	logic [7:0] n;
	n = 8'h00;
	while (pick(sel) !== 1'b1)
		@(posedge i_clk) #1;
	@(posedge i_clk) #1;
	n = 8'h01;
	while (pick(sel) !== 1'b1 && n != 8'hFF)
	begin
		@(posedge i_clk) #1;
		n++;
	end
	chk(n, exp);
endtask
task automatic end_of_test;
	$display("checks %0d errors %0d", num_checks, err_count);
	if (err_count == 0 && num_checks > 0)
		$display("Regression OK");
	else
		$display("Regression broken");
	$finish;
endtask
task automatic t_reset;
	rd(16'hFFA0, 8'h00);
	rd(16'hFFA1, 8'h00);
	rd(16'hFFFB, 8'h00);
	rd(16'hFFA5, 8'h00);
	chk({7'h00, o_periph_on_internal}, 8'h01);
endtask
task automatic t_to_x1;
	wr(16'hFFA0, 8'h01);
	rd(16'hFFA0, 8'h00);
	wr(16'hFFA1, 8'h03);
	settle(1'b0);
	rd(16'hFFA1, 8'h03);
	chk({7'h00, o_x1_osc_stop}, 8'h00);
endtask
task automatic t_int_stop;
	wr(16'hFFA0, 8'h01);
	rd(16'hFFA0, 8'h00);
	@(posedge i_clk);
	i_int_osc_sw_stoppable <= 1'b1;
	repeat (3) @(posedge i_clk);
	wr(16'hFFA0, 8'hFF);
	rd(16'hFFA0, 8'h01);
	chk({7'h00, o_internal_osc_stop}, 8'h01);
	wr(16'hFFA0, 8'h00);
	chk({7'h00, o_internal_osc_stop}, 8'h00);
endtask
task automatic t_sub;
	wr(16'hFFFB, 8'h10);
	repeat (10) @(posedge i_clk);
	rd(16'hFFFB, 8'h30);
	wr(16'hFFFB, 8'h90);
	chk({7'h00, o_x1_osc_stop}, 8'h01);
	wr(16'hFFFB, 8'h10);
	chk({7'h00, o_x1_osc_stop}, 8'h00);
	wr(16'hFFFB, 8'h00);
	repeat (10) @(posedge i_clk);
	rd(16'hFFFB, 8'h00);
	chk({7'h00, o_periph_on_internal}, 8'h00);
endtask
task automatic t_x1_stop;
	wr(16'hFFFB, 8'h80);
	chk({7'h00, o_x1_osc_stop}, 8'h00);
	wr(16'hFFFB, 8'h00);
	wr(16'hFFA1, 8'h02);
	settle(1'b1);
	rd(16'hFFA1, 8'h00);
	wr(16'hFFFB, 8'h80);
	chk({7'h00, o_x1_osc_stop}, 8'h00);
	wr(16'hFFA2, 8'h80);
	chk({7'h00, o_x1_osc_stop}, 8'h01);
	wr(16'hFFA2, 8'h00);
	wr(16'hFFFB, 8'h41);
	rd(16'hFFFB, 8'h41);
	chk({7'h00, o_sub_feedback_resistor_off}, 8'h01);
	gap(2'h0, 8'h40);
	gap(2'h1, 8'h20);
	gap(2'h2, 8'h80);
endtask
initial
begin
	tc = 7'h00;
	{i_nrst, i_wr, i_rd, i_int_osc_sw_stoppable} = 4'h0;
	{i_x1_clk_tick, i_int_osc_tick, i_sub_clk_tick} = 3'h0;
	i_addr = 16'h0000;
	i_wdata = 8'h00;
	repeat (8) @(posedge i_clk);
	i_nrst <= 1'b1;
	t_reset;
	t_to_x1;
	t_int_stop;
	t_sub;
	t_x1_stop;
	end_of_test;
end
initial
begin
	#100000;
	err_count++;
	end_of_test;
end
endmodule // cpu_clock_source_select_test
`default_nettype wire
